/* File: rtl/avl_pkg.sv */
// Constants and types shared by the automatic volume leveler and its register file
package avl_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [8:0] IDX_CTRL   = 9'h124;
    localparam logic [8:0] IDX_THR    = 9'h126;
    localparam logic [8:0] IDX_ATK    = 9'h128;
    localparam logic [8:0] IDX_DCY    = 9'h12a;
    localparam logic [8:0] IDX_STATUS = 9'h13c;
    // Coefficient halves, entries in order B1, B2, A1, A2
    localparam logic [3:0][8:0] IDX_COEF_HI = {9'h138, 9'h134, 9'h130, 9'h12c};
    localparam logic [3:0][8:0] IDX_COEF_LO = {9'h13a, 9'h136, 9'h132, 9'h12e};

    // ------------------------------------------------------------
    // Control field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL_EN_BIT   = 0;
    localparam int CTL_HARD_BIT = 5;
    localparam int CTL_RESP_LSB = 8;
    localparam int CTL_MAXG_LSB = 12;
    localparam int CTL_RSV_BIT  = 14;
    localparam logic [1:0]  RST_RESP = 2'h1;
    localparam logic [1:0]  RST_MAXG = 2'h1;
    localparam logic        RST_RSV  = 1'h1;
    localparam logic [15:0] RST_THR  = 16'h1473;
    localparam logic [11:0] RST_ATK  = 12'h028;
    localparam logic [11:0] RST_DCY  = 12'h050;

    // ------------------------------------------------------------
    // Gain arithmetic (unsigned Q4.20)
    // ------------------------------------------------------------
    localparam int          GAIN_W     = 24;
    localparam int          GAIN_FRAC  = 20;
    localparam int          ATK_SHIFT  = 19;
    localparam int          DCY_SHIFT  = 23;
    localparam logic [23:0] GAIN_UNITY = 24'h100000;
    localparam logic [23:0] GAIN_6DB   = 24'h200000;
    localparam logic [23:0] GAIN_12DB  = 24'h400000;
    localparam logic [15:0] MAG_MAX    = 16'h7fff;

    // Maximum gain codes
    typedef enum logic [1:0] {
        AVL_G0  = 2'b00,
        AVL_G6  = 2'b01,
        AVL_G12 = 2'b10,
        AVL_GX  = 2'b11
    } avl_maxg_t;

    // Leveler activity shown in the status register
    typedef enum logic [1:0] {
        AVL_BYPASS = 2'b00,
        AVL_HOLD   = 2'b01,
        AVL_ATTACK = 2'b10,
        AVL_DECAY  = 2'b11
    } avl_mode_t;

endpackage

/* File: rtl/avl_scale.sv */
// Applies the leveler gain to one sample with saturation and reports its magnitude
module avl_scale (
    // Sample in
    input  wire logic signed [15:0] smp,
    input  wire logic        [23:0] gain,
    // Scaled sample out
    output logic signed      [15:0] y,
    output logic             [15:0] mag
);
    import avl_pkg::*;

    logic signed [40:0] prod;
    logic signed [20:0] shifted;

    // Saturate rather than wrap: a wrapped peak would look quiet and drive gain up
    always_comb begin
        prod    = smp * $signed({1'b0, gain});
        shifted = 21'(prod >>> GAIN_FRAC);
        if (shifted > 21'sh007fff) begin
            y = 16'sh7fff;
        end else if (shifted < -21'sh008000) begin
            y = -16'sh8000;
        end else begin
            y = shifted[15:0];
        end
        mag = y[15] ? 16'(-y) : 16'(y);
        if (mag > MAG_MAX) begin
            mag = MAG_MAX;
        end
    end

endmodule

/* File: rtl/avl_step.sv */
// Gain step for one sample: gain times a rate code, scaled by a fixed power of two
module avl_step #(
    parameter int SHIFT = 19
) (
    // Operands
    input  wire logic [23:0] gain,
    input  wire logic [11:0] rate,
    // Step size
    output logic      [23:0] step
);
    logic [35:0] prod;

    // Relative step keeps the rate constant in dB per second at any gain
    always_comb begin
        prod = gain * rate;
        step = 24'(prod >> SHIFT);
    end

endmodule

/* File: rtl/avl_leveler.sv */
// Automatic volume leveler with its Wishbone register file and coefficient staging
//
// Implementation choice: the Wishbone register port.
module avl_leveler
    import avl_pkg::*;
(
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                arst_n,
    // Wishbone classic slave
    input  wire logic                wbCyc,
    input  wire logic                wbStb,
    input  wire logic                wbWe,
    input  wire logic [10:0]         wbAdr,
    input  wire logic [3:0]          wbSel,
    input  wire logic [31:0]         wbDatW,
    output logic      [31:0]         wbDatR,
    output logic                     wbAck,
    // Audio in, one strobe per sample period
    input  wire logic signed [15:0]  smpIn,
    input  wire logic                smpInValid,
    // Audio out
    output logic signed [15:0]       smpOut,
    output logic                     smpOutValid,
    // Coefficient staging toward the equalizer loader
    output logic [3:0][15:0]         coefUpper,
    output logic [3:0][3:0]          coefLower,
    // Current gain
    output logic [23:0]              gainNow
);
    import avl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic              ack;
        logic [31:0]       rdat;
        logic              en;
        logic              hard;
        logic              rsv;
        logic [1:0]        resp;
        avl_maxg_t         maxg;
        logic [15:0]       thr;
        logic [11:0]       atk;
        logic [11:0]       dcy;
        logic [3:0][15:0]  cHi;
        logic [3:0][3:0]   cLo;
        logic [23:0]       gain;
        avl_mode_t         mode;
        logic signed [15:0] out;
        logic              outV;
    } avl_state_t;

    localparam avl_state_t RST_STATE = '{
        ack: 1'b0, rdat: 32'h0, en: 1'b0, hard: 1'b0, rsv: RST_RSV,
        resp: RST_RESP, maxg: avl_maxg_t'(RST_MAXG), thr: RST_THR,
        atk: RST_ATK, dcy: RST_DCY, cHi: '0, cLo: '0, gain: GAIN_UNITY,
        mode: AVL_BYPASS, out: 16'sh0, outV: 1'b0};

    avl_state_t s_q;
    avl_state_t s_d;

    logic              busReq;
    logic [8:0]        idx;
    logic [15:0]       ctlWord;
    logic [15:0]       rdWord;
    logic [15:0]       thrMag;
    logic [23:0]       maxGain;
    logic [23:0]       capGain;
    logic signed [15:0] scaled;
    logic [15:0]       mag;
    logic [23:0]       atkStep;
    logic [23:0]       dcyStep;

    // Merge a 16-bit write under the two low byte enables
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] sel);
        merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------
    avl_scale u_scale (
        .smp  (smpIn),
        .gain (capGain),
        .y    (scaled),
        .mag  (mag)
    );

    avl_step #(.SHIFT(ATK_SHIFT)) u_atk (
        .gain (capGain),
        .rate (s_q.atk),
        .step (atkStep)
    );

    avl_step #(.SHIFT(DCY_SHIFT)) u_dcy (
        .gain (capGain),
        .rate (s_q.dcy),
        .step (dcyStep)
    );

    // Gain ceiling chosen by the maximum gain code; the spare code acts as 12 dB
    always_comb begin
        case (s_q.maxg)
            AVL_G0:  maxGain = GAIN_UNITY;
            AVL_G6:  maxGain = GAIN_6DB;
            AVL_G12: maxGain = GAIN_12DB;
            default: maxGain = GAIN_12DB;
        endcase
        // Lowering the ceiling takes effect on the very next sample
        capGain = (s_q.gain > maxGain) ? maxGain : s_q.gain;
        thrMag  = (s_q.thr > MAG_MAX) ? MAG_MAX : s_q.thr;
    end

    // ------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------
    assign busReq  = wbCyc & wbStb & ~s_q.ack;
    assign idx     = wbAdr[10:2];
    assign ctlWord = {1'b0, s_q.rsv, s_q.maxg, 2'b00, s_q.resp, 2'b00, s_q.hard, 4'h0, s_q.en};

    // Unmapped indices read zero and still acknowledge
    always_comb begin
        rdWord = 16'h0;
        case (idx)
            IDX_CTRL:   rdWord = ctlWord;
            IDX_THR:    rdWord = s_q.thr;
            IDX_ATK:    rdWord = {4'h0, s_q.atk};
            IDX_DCY:    rdWord = {4'h0, s_q.dcy};
            IDX_STATUS: rdWord = {s_q.mode, 1'b0, s_q.gain[GAIN_W-1:GAIN_W-13]};
            default:    rdWord = 16'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            if (idx == IDX_COEF_HI[i]) begin
                rdWord = s_q.cHi[i];
            end
            if (idx == IDX_COEF_LO[i]) begin
                rdWord = {12'h000, s_q.cLo[i]};
            end
        end
    end

    // ------------------------------------------------------------
    // Next state: bus access and per-sample leveling
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] w;
        w      = 16'h0;
        s_d      = s_q;
        s_d.ack  = 1'b0;
        s_d.outV = 1'b0;
        // Single-cycle answer; ack is forced low the cycle after so a held strobe is not retaken
        if (busReq) begin
            s_d.ack  = 1'b1;
            s_d.rdat = {16'h0, rdWord};
            if (wbWe) begin
                case (idx)
                    IDX_CTRL: begin
                        w        = merge16(ctlWord, wbDatW[15:0], wbSel[1:0]);
                        s_d.en   = w[CTL_EN_BIT];
                        s_d.hard = w[CTL_HARD_BIT];
                        s_d.resp = w[CTL_RESP_LSB +: 2];
                        s_d.maxg = avl_maxg_t'(w[CTL_MAXG_LSB +: 2]);
                        s_d.rsv  = w[CTL_RSV_BIT];
                    end
                    IDX_THR: s_d.thr = merge16(s_q.thr, wbDatW[15:0], wbSel[1:0]);
                    IDX_ATK: begin
                        w        = merge16({4'h0, s_q.atk}, wbDatW[15:0], wbSel[1:0]);
                        s_d.atk  = w[11:0];
                    end
                    IDX_DCY: begin
                        w        = merge16({4'h0, s_q.dcy}, wbDatW[15:0], wbSel[1:0]);
                        s_d.dcy  = w[11:0];
                    end
                    default: w = 16'h0;
                endcase
                for (int i = 0; i < 4; i++) begin
                    if (idx == IDX_COEF_HI[i]) begin
                        s_d.cHi[i] = merge16(s_q.cHi[i], wbDatW[15:0], wbSel[1:0]);
                    end
                    if (idx == IDX_COEF_LO[i] && wbSel[0]) begin
                        s_d.cLo[i] = wbDatW[3:0];
                    end
                end
            end
        end
        // One decision per sample strobe
        if (smpInValid) begin
            s_d.outV = 1'b1;
            if (!s_q.en) begin
                s_d.out  = smpIn;
                s_d.gain = GAIN_UNITY;
                s_d.mode = AVL_BYPASS;
            end else begin
                s_d.out = scaled;
                // Hard limit clips at the threshold instead of waiting for attack
                if (s_q.hard && mag > thrMag) begin
                    s_d.out = scaled[15] ? 16'(-thrMag) : thrMag;
                end
                if (mag > thrMag) begin
                    s_d.gain = capGain - atkStep;
                    s_d.mode = AVL_ATTACK;
                end else if (capGain < maxGain) begin
                    // Release never overshoots the ceiling
                    s_d.gain = (maxGain - capGain < dcyStep) ? maxGain : capGain + dcyStep;
                    s_d.mode = AVL_DECAY;
                end else begin
                    s_d.gain = capGain;
                    s_d.mode = AVL_HOLD;
                end
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign wbAck       = s_q.ack;
    assign wbDatR      = s_q.rdat;
    assign smpOut      = s_q.out;
    assign smpOutValid = s_q.outV;
    assign coefUpper   = s_q.cHi;
    assign coefLower   = s_q.cLo;
    assign gainNow     = s_q.gain;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_loud;
        smpInValid && s_q.en && mag > thrMag;
    endsequence

    sequence s_quiet;
        smpInValid && s_q.en && mag <= thrMag && capGain < maxGain;
    endsequence

    property p_gain_cap;
        // Ceiling of the sample's own cycle: a control write may land on that same edge
        smpInValid && s_q.en |=> s_q.gain <= (($past(s_q.maxg) == AVL_G0) ? GAIN_UNITY :
                                             ($past(s_q.maxg) == AVL_G6) ? GAIN_6DB : GAIN_12DB);
    endproperty
    a_gain_cap: assert property (p_gain_cap) else $error("gain above ceiling");

    property p_maxg_reset;
        $rose(arst_n) |-> s_q.maxg == AVL_G6;
    endproperty
    a_maxg_reset: assert property (p_maxg_reset) else $error("max gain reset wrong");

    property p_attack;
        s_loud |=> s_q.mode == AVL_ATTACK && s_q.gain <= $past(capGain);
    endproperty
    a_attack: assert property (p_attack) else $error("attack did not cut gain");

    property p_decay;
        s_quiet |=> s_q.mode == AVL_DECAY && s_q.gain >= $past(capGain);
    endproperty
    a_decay: assert property (p_decay) else $error("decay did not release");

    property p_hi_write;
        wbCyc && wbStb && wbWe && !s_q.ack && idx == IDX_COEF_HI[0] && wbSel[1:0] == 2'b11
            |=> wbAck ##0 coefUpper[0] == $past(wbDatW[15:0]);
    endproperty
    a_hi_write: assert property (p_hi_write) else $error("upper half not stored");

    sequence s_lo_read;
        wbCyc && wbStb && !wbWe && !s_q.ack &&
            (idx == IDX_COEF_LO[0] || idx == IDX_COEF_LO[1] ||
             idx == IDX_COEF_LO[2] || idx == IDX_COEF_LO[3]);
    endsequence

    property p_lo_read;
        s_lo_read |=> wbAck && wbDatR[31:4] == 28'h0;
    endproperty
    a_lo_read: assert property (p_lo_read) else $error("lower half high bits nonzero");

    property p_bypass;
        smpInValid && !s_q.en |=> smpOutValid && smpOut == $past(smpIn) && gainNow == GAIN_UNITY;
    endproperty
    a_bypass: assert property (p_bypass) else $error("disabled leveler altered audio");

    property p_ack;
        wbCyc && wbStb && !s_q.ack |=> wbAck ##1 !wbAck;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    // The output strobe is a one-cycle answer to a sample and nothing else
    property p_out_pulse;
        !smpInValid |=> !smpOutValid;
    endproperty
    a_out_pulse: assert property (p_out_pulse) else $error("output strobe without sample");

endmodule

/* File: tb/test_avl_leveler.sv */
// Self-checking bench for the automatic volume leveler and its register file
module test_avl_leveler;
    timeunit 1ns;
    timeprecision 1ps;
    import avl_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                core_clk    = 1'b0;
    logic                arst_n      = 1'b0;
    logic                wbCyc       = 1'b0;
    logic                wbStb       = 1'b0;
    logic                wbWe        = 1'b0;
    logic [10:0]         wbAdr       = 11'h000;
    logic [3:0]          wbSel       = 4'h0;
    logic [31:0]         wbDatW      = 32'h0;
    logic [31:0]         wbDatR;
    logic                wbAck;
    logic signed [15:0]  smpIn       = 16'h0000;
    logic                smpInValid  = 1'b0;
    logic signed [15:0]  smpOut;
    logic                smpOutValid;
    logic [3:0][15:0]    coefUpper;
    logic [3:0][3:0]     coefLower;
    logic [23:0]         gainNow;
    // Reference state of the leveler
    logic [23:0]         gm          = GAIN_UNITY;
    logic [1:0]          md          = 2'h0;
    logic [1:0]          maxg        = 2'h1;
    logic                en          = 1'b0;
    logic                hard        = 1'b0;
    logic [15:0]         thr         = RST_THR;
    logic [11:0]         atk         = RST_ATK;
    logic [11:0]         dcy         = RST_DCY;
    int                  errors      = 0;
    int                  comparisons = 0;

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    avl_leveler uut (
        .core_clk    (core_clk),
        .arst_n      (arst_n),
        .wbCyc       (wbCyc),
        .wbStb       (wbStb),
        .wbWe        (wbWe),
        .wbAdr       (wbAdr),
        .wbSel       (wbSel),
        .wbDatW      (wbDatW),
        .wbDatR      (wbDatR),
        .wbAck       (wbAck),
        .smpIn       (smpIn),
        .smpInValid  (smpInValid),
        .smpOut      (smpOut),
        .smpOutValid (smpOutValid),
        .coefUpper   (coefUpper),
        .coefLower   (coefLower),
        .gainNow     (gainNow)
    );

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic final_report;
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic cycle; ack and read data are taken at the edge that samples ack high
    task automatic wb(input logic we, input logic [8:0] idx, input logic [3:0] sel,
                      input logic [15:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbSel <= sel;
        wbDatW <= {16'h0, dat};
        do begin
            @(posedge core_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            final_report;
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] idx, input logic [3:0] sel, input logic [15:0] dat);
        logic [31:0] r;
        wb(1'b1, idx, sel, dat, r);
    endtask

    task automatic rdchk(input logic [8:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, idx, 4'h3, 16'h0, r);
        chk(r, exp);
    endtask

    // Expected {mode, next gain, output} for one sample, from the current state
    function automatic logic [41:0] lev_model(input logic signed [15:0] x);
        logic [23:0] c;
        logic [23:0] g;
        logic [23:0] n;
        logic [1:0]  m;
        longint      p;
        longint      t;
        longint      mg;
        if (!en) return {2'h0, GAIN_UNITY, x};
        c = (maxg == 2'h0) ? GAIN_UNITY : (maxg == 2'h1) ? GAIN_6DB : GAIN_12DB;
        g = (gm > c) ? c : gm;
        p = (longint'(x) * longint'(g)) >>> GAIN_FRAC;
        if (p > 32767) p = 32767;
        if (p < -32768) p = -32768;
        mg = (p < 0) ? -p : p;
        if (mg > 32767) mg = 32767;
        t = (thr > MAG_MAX) ? longint'(MAG_MAX) : longint'(thr);
        if (mg > t) begin
            n = g - 24'((longint'(g) * longint'(atk)) >> ATK_SHIFT);
            m = 2'h2;
            if (hard) p = (p < 0) ? -t : t;
        end else if (g < c) begin
            n = g + 24'((longint'(g) * longint'(dcy)) >> DCY_SHIFT);
            if (n > c) n = c;
            m = 2'h3;
        end else begin
            n = g;
            m = 2'h1;
        end
        return {m, n, 16'(p)};
    endfunction

    // One sample in, its answer checked one cycle later
    task automatic send(input logic signed [15:0] x);
        logic [41:0] e;
        e = lev_model(x);
        @(posedge core_clk);
        smpIn <= x;
        smpInValid <= 1'b1;
        @(posedge core_clk);
        smpInValid <= 1'b0;
        #1;
        chk({31'h0, smpOutValid}, 32'h1);
        chk({16'h0, smpOut}, {16'h0, e[15:0]});
        chk({8'h0, gainNow}, {8'h0, e[39:16]});
        gm = e[39:16];
        md = e[41:40];
    endtask

    // ------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge core_clk);
        errors++;
        final_report;
    end

    initial begin
        logic [19:0] c20;
        logic [15:0] x;
        logic [1:0]  codes [4];
        codes = '{2'h2, 2'h0, 2'h1, 2'h3};
        void'($urandom(32'hb6d4));
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values
        rdchk(IDX_CTRL, 32'h5100);
        rdchk(IDX_THR, 32'h1473);
        rdchk(IDX_ATK, 32'h0028);
        rdchk(IDX_DCY, 32'h0050);
        // Coefficient halves; a write without the low lane must not touch the lower half
        for (int i = 0; i < 4; i++) begin
            rdchk(IDX_COEF_LO[i], 32'h0);
            c20 = 20'($urandom);
            wr(IDX_COEF_HI[i], 4'h3, c20[19:4]);
            wr(IDX_COEF_LO[i], 4'h3, {12'($urandom), c20[3:0]});
            wr(IDX_COEF_LO[i], 4'h2, {12'hfff, ~c20[3:0]});
            rdchk(IDX_COEF_HI[i], {16'h0, c20[19:4]});
            rdchk(IDX_COEF_LO[i], {28'h0, c20[3:0]});
            chk({16'h0, coefUpper[i]}, {16'h0, c20[19:4]});
            chk({28'h0, coefLower[i]}, {28'h0, c20[3:0]});
        end
        // Reserved bits, byte lanes and an unmapped place
        wr(IDX_ATK, 4'h3, 16'hffff);
        rdchk(IDX_ATK, 32'h0fff);
        wr(IDX_DCY, 4'h3, 16'hffff);
        rdchk(IDX_DCY, 32'h0fff);
        wr(IDX_THR, 4'h3, 16'h1234);
        wr(IDX_THR, 4'h1, 16'habcd);
        rdchk(IDX_THR, 32'h12cd);
        wr(9'h13e, 4'h3, 16'hffff);
        rdchk(9'h13e, 32'h0);
        // Disabled leveler passes audio untouched
        repeat (8) send(16'($urandom));
        // Every gain code, mostly quiet audio with loud bursts
        foreach (codes[k]) begin
            maxg = codes[k];
            hard = maxg[0];
            en = 1'b1;
            thr = 16'h0400 + 16'($urandom % 15360);
            atk = 12'($urandom);
            dcy = 12'h800 | 12'($urandom);
            wr(IDX_THR, 4'h3, thr);
            wr(IDX_ATK, 4'h3, {4'h0, atk});
            wr(IDX_DCY, 4'h3, {4'h0, dcy});
            wr(IDX_CTRL, 4'h3, 16'h4101 | {2'h0, maxg, 12'h0} | {10'h0, hard, 5'h0});
            rdchk(IDX_CTRL, {16'h0, 16'h4101 | {2'h0, maxg, 12'h0} | {10'h0, hard, 5'h0}});
            repeat (1500) begin
                x = 16'($urandom);
                if ($urandom % 8 != 0) x = {{6{x[9]}}, x[9:0]};
                send(x);
            end
            rdchk(IDX_STATUS, {16'h0, md, 1'b0, gm[23:11]});
        end
        // Switching off returns to plain pass-through at unity gain
        en = 1'b0;
        wr(IDX_CTRL, 4'h3, 16'h4100);
        repeat (4) send(16'($urandom));
        final_report;
    end
endmodule
